// ---- hw/tcg_edge_arm.sv ----
// module: falling-edge arming and rising-edge count pulse of the external count input
module tcg_edge_arm
   import tcg_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // control
   input wire logic enable,
   input wire logic disarm,
   input wire logic level,
   // result
   output logic count_pulse,
   output logic armed
);

   logic prev_reg;
   logic armed_reg;
   logic en_prev_reg;
   logic high_at_off_reg;
   logic fall;
   logic rise;
   logic reenable_low;
   logic armed_next;

   // ----------------------------------------
   // edge detection and arming
   // ----------------------------------------
   assign fall = prev_reg & ~level;
   assign rise = ~prev_reg & level;
   assign reenable_low = enable & ~en_prev_reg & high_at_off_reg & ~level;
   assign armed_next = (disarm | reenable_low) ? 1'b0 :
                       ((enable & fall) ? 1'b1 : armed_reg);
   assign count_pulse = enable & armed_reg & rise;
   assign armed = armed_reg;

   always_ff @(posedge clk) begin
      if (srst) begin
         prev_reg <= 1'b0;
         armed_reg <= 1'b0;
         en_prev_reg <= 1'b0;
         high_at_off_reg <= 1'b0;
      end else begin
         prev_reg <= level;
         armed_reg <= armed_next;
         en_prev_reg <= enable;
         if (en_prev_reg & ~enable) begin
            high_at_off_reg <= level;
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_write_disarms: assert property (@(posedge clk) disable iff (srst)
      disarm |=> !armed_reg) else $error("counter write did not disarm");
   a_unarmed_no_count: assert property (@(posedge clk) disable iff (srst)
      !armed_reg |-> !count_pulse) else $error("count pulse while disarmed");
   a_rise_counts: assert property (@(posedge clk) disable iff (srst)
      (enable && armed_reg && $rose(level)) |-> count_pulse) else $error("armed rise lost");
   a_reenable_low: assert property (@(posedge clk) disable iff (srst)
      (enable && !en_prev_reg && high_at_off_reg && !level) |=> !armed_reg)
      else $error("re-enable low did not disarm");

endmodule

// ---- hw/tcg_pkg.sv ----
// package: register map, control layout, bus states and timing constants of the timer block
package tcg_pkg;

   // ----------------------------------------
   // register byte offsets on the bus
   // ----------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CNT_LO = 8'h04;
   localparam logic [7:0] OFS_CNT_HI = 8'h08;
   localparam logic [7:0] OFS_IRQ_EN = 8'h0C;
   localparam logic [7:0] OFS_IRQ_CTRL = 8'h10;
   localparam logic [7:0] OFS_PIR1 = 8'h14;
   localparam logic [7:0] OFS_APF = 8'h18;

   // ----------------------------------------
   // implemented bit masks and reset values
   // ----------------------------------------
   localparam logic [7:0] IRQ_EN_MASK = 8'h6B;
   localparam logic [7:0] APF_MASK = 8'h10;
   localparam logic [7:0] IRQ_CTRL_MASK = 8'h40;
   localparam logic [7:0] PIR1_MASK = 8'h01;
   localparam logic [7:0] REG_RESET = 8'h00;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int IRQ_EN_ADC_BIT = 6;
   localparam int IRQ_EN_CCP_BIT = 5;
   localparam int IRQ_EN_CMP_BIT = 3;
   localparam int IRQ_EN_TMR2_BIT = 1;
   localparam int IRQ_EN_OVF_BIT = 0;
   localparam int APF_GATE_SEL_BIT = 4;
   localparam int IRQ_CTRL_GATE_BIT = 6;
   localparam int PIR1_OVF_BIT = 0;

   // ----------------------------------------
   // timing: one instruction cycle is four system clocks
   // ----------------------------------------
   localparam int INSTR_CLKS = 4;
   localparam logic [1:0] INSTR_LAST = 2'(INSTR_CLKS - 1);

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef struct packed {
      logic gate_invert;
      logic gate_enable;
      logic [1:0] prescale_select;
      logic crystal_enable;
      logic sync_disable;
      logic clock_source;
      logic timer_on;
   } tcg_ctrl_t;

   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_RD_WAIT = 1'b1
   } tcg_bus_st_t;

endpackage

// ---- hw/tcg_timer.sv ----
// module: 16-bit timer/counter with clock, gate and interrupt enable logic behind AHB-Lite
module tcg_timer
   import tcg_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // pins and system state
   input wire logic external_count_clock_pin,
   input wire logic crystal_osc_clock,
   input wire logic master_clear_shared_pin,
   input wire logic osc_output_shared_pin,
   input wire logic internal_oscillator_no_clkout,
   input wire logic sleep,
   // interrupt request and wake
   output logic irq,
   output logic wake
);

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   tcg_ctrl_t ctrl_reg;
   logic [7:0] irq_en_reg;
   logic [7:0] apf_reg;
   logic periph_gate_reg;
   logic ovf_flag_reg;
   logic [15:0] count_reg;
   logic [2:0] pre_reg;
   logic [1:0] icyc_reg;
   logic sync1_reg;
   logic sync2_reg;
   tcg_bus_st_t bus_st_reg;
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic [7:0] rd_addr_reg;
   logic [31:0] hrdata_reg;
   logic hreadyout_reg;
   logic irq_reg;
   logic wake_reg;

   logic addr_ok;
   logic [7:0] wdat;
   logic wr_ctrl;
   logic wr_lo;
   logic wr_hi;
   logic wr_irq_en;
   logic wr_irq_ctrl;
   logic wr_pir1;
   logic wr_apf;
   logic cnt_wr;
   logic [7:0] rd_mux;
   logic icyc_tick;
   logic src_level;
   logic ext_level;
   logic ext_pulse;
   logic ext_armed;
   logic ext_ok;
   logic count_src;
   logic gate_level;
   logic gate_ok;
   logic advance;
   logic [2:0] div_last;
   logic inc;
   logic ovf_evt;
   logic [15:0] count_inc;
   logic [15:0] count_next;
   logic [2:0] pre_next;
   logic ovf_flag_next;
   logic irq_next;

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   assign addr_ok = hsel & htrans[1] & hready;
   assign wdat = hwdata[7:0];
   assign wr_ctrl = wr_pend_reg & (wr_addr_reg == OFS_CTRL);
   assign wr_lo = wr_pend_reg & (wr_addr_reg == OFS_CNT_LO);
   assign wr_hi = wr_pend_reg & (wr_addr_reg == OFS_CNT_HI);
   assign wr_irq_en = wr_pend_reg & (wr_addr_reg == OFS_IRQ_EN);
   assign wr_irq_ctrl = wr_pend_reg & (wr_addr_reg == OFS_IRQ_CTRL);
   assign wr_pir1 = wr_pend_reg & (wr_addr_reg == OFS_PIR1);
   assign wr_apf = wr_pend_reg & (wr_addr_reg == OFS_APF);
   assign cnt_wr = wr_lo | wr_hi;

   // unmapped offsets read as zero
   assign rd_mux = (rd_addr_reg == OFS_CTRL) ? ctrl_reg :
                   (rd_addr_reg == OFS_CNT_LO) ? count_reg[7:0] :
                   (rd_addr_reg == OFS_CNT_HI) ? count_reg[15:8] :
                   (rd_addr_reg == OFS_IRQ_EN) ? (irq_en_reg & IRQ_EN_MASK) :
                   (rd_addr_reg == OFS_IRQ_CTRL) ? {1'b0, periph_gate_reg, 6'h00} :
                   (rd_addr_reg == OFS_PIR1) ? {7'h00, ovf_flag_reg} :
                   (rd_addr_reg == OFS_APF) ? (apf_reg & APF_MASK) :
                   8'h00;

   // ----------------------------------------
   // bus slave: writes zero-wait, reads one wait state
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         bus_st_reg <= BUS_IDLE;
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         rd_addr_reg <= 8'h00;
         hrdata_reg <= 32'h0000_0000;
         hreadyout_reg <= 1'b1;
      end else begin
         unique case (bus_st_reg)
            BUS_IDLE: begin
               wr_pend_reg <= addr_ok & hwrite;
               if (addr_ok) begin
                  wr_addr_reg <= haddr[7:0];
                  rd_addr_reg <= haddr[7:0];
               end
               if (addr_ok & ~hwrite) begin
                  bus_st_reg <= BUS_RD_WAIT;
                  hreadyout_reg <= 1'b0;
               end
            end
            BUS_RD_WAIT: begin
               wr_pend_reg <= 1'b0;
               hrdata_reg <= {24'h00_0000, rd_mux};
               hreadyout_reg <= 1'b1;
               bus_st_reg <= BUS_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // software registers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_reg <= REG_RESET;
         irq_en_reg <= REG_RESET;
         apf_reg <= REG_RESET;
         periph_gate_reg <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= wdat;
         end
         if (wr_irq_en) begin
            irq_en_reg <= wdat & IRQ_EN_MASK;
         end
         if (wr_apf) begin
            apf_reg <= wdat & APF_MASK;
         end
         if (wr_irq_ctrl) begin
            periph_gate_reg <= wdat[IRQ_CTRL_GATE_BIT];
         end
      end
   end

   // ----------------------------------------
   // count source selection
   // ----------------------------------------
   assign icyc_tick = (icyc_reg == INSTR_LAST);
   assign src_level = (ctrl_reg.crystal_enable & internal_oscillator_no_clkout) ?
                      crystal_osc_clock :
                      external_count_clock_pin;
   assign ext_level = ctrl_reg.sync_disable ? src_level : sync2_reg;
   assign ext_ok = ctrl_reg.sync_disable | ~sleep;
   assign count_src = ctrl_reg.clock_source ? (ext_pulse & ext_ok) :
                      (icyc_tick & ~sleep);
   assign gate_level = apf_reg[APF_GATE_SEL_BIT] ? master_clear_shared_pin :
                       osc_output_shared_pin;
   assign gate_ok = ~ctrl_reg.gate_enable | (gate_level == ctrl_reg.gate_invert);
   assign advance = ctrl_reg.timer_on & gate_ok & count_src & ~cnt_wr;

   always_ff @(posedge clk) begin
      if (srst) begin
         icyc_reg <= 2'b00;
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
      end else begin
         icyc_reg <= icyc_reg + 2'b01;
         sync1_reg <= src_level;
         sync2_reg <= sync1_reg;
      end
   end

   tcg_edge_arm tcg_edge_arm_inst (
      .clk(clk),
      .srst(srst),
      .enable(ctrl_reg.timer_on & ctrl_reg.clock_source),
      .disarm(cnt_wr),
      .level(ext_level),
      .count_pulse(ext_pulse),
      .armed(ext_armed)
   );

   // ----------------------------------------
   // prescaler and counter
   // ----------------------------------------
   assign div_last = 3'((4'b0001 << ctrl_reg.prescale_select) - 4'b0001);
   assign inc = advance & (pre_reg == div_last);
   assign pre_next = cnt_wr ? 3'b000 :
                     (inc ? 3'b000 : (advance ? pre_reg + 3'b001 : pre_reg));
   assign count_inc = count_reg + 16'h0001;
   assign count_next = wr_lo ? {count_reg[15:8], wdat} :
                       wr_hi ? {wdat, count_reg[7:0]} :
                       (inc ? count_inc : count_reg);
   assign ovf_evt = inc & (count_reg == 16'hFFFF);
   assign ovf_flag_next = ovf_evt | (ovf_flag_reg & ~(wr_pir1 & ~wdat[PIR1_OVF_BIT]));
   assign irq_next = ovf_flag_reg & irq_en_reg[IRQ_EN_OVF_BIT] & periph_gate_reg;

   always_ff @(posedge clk) begin
      if (srst) begin
         pre_reg <= 3'b000;
         count_reg <= 16'h0000;
         ovf_flag_reg <= 1'b0;
         irq_reg <= 1'b0;
         wake_reg <= 1'b0;
      end else begin
         pre_reg <= pre_next;
         count_reg <= count_next;
         ovf_flag_reg <= ovf_flag_next;
         irq_reg <= irq_next;
         wake_reg <= irq_next & sleep;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign hrdata = hrdata_reg;
   assign hreadyout = hreadyout_reg;
   assign hresp = 1'b0;
   assign irq = irq_reg;
   assign wake = wake_reg;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_internal_tick: assert property (@(posedge clk) disable iff (srst)
      (ctrl_reg.timer_on && !ctrl_reg.clock_source && !sleep && gate_ok && icyc_tick
       && ctrl_reg.prescale_select == 2'b00 && !cnt_wr)
      |=> count_reg == $past(count_reg) + 16'h0001) else $error("internal tick lost");
   a_prescale_clear: assert property (@(posedge clk) disable iff (srst)
      cnt_wr |=> pre_reg == 3'b000) else $error("prescaler not cleared on write");
   a_prescale_div: assert property (@(posedge clk) disable iff (srst)
      inc |-> pre_reg == div_last) else $error("prescale ratio wrong");
   a_gate_holds: assert property (@(posedge clk) disable iff (srst)
      (ctrl_reg.gate_enable && gate_level != ctrl_reg.gate_invert && !cnt_wr)
      |=> $stable(count_reg)) else $error("counted with gate closed");
   a_overflow_flag: assert property (@(posedge clk) disable iff (srst)
      (inc && count_reg == 16'hFFFF) |=> ovf_flag_reg && count_reg == 16'h0000)
      else $error("rollover did not set flag");
   a_irq_gate: assert property (@(posedge clk) disable iff (srst)
      !periph_gate_reg |=> !irq_reg) else $error("interrupt without peripheral gate");
   a_irq_raise: assert property (@(posedge clk) disable iff (srst)
      (ovf_flag_reg && irq_en_reg[IRQ_EN_OVF_BIT] && periph_gate_reg) |=> irq_reg)
      else $error("enabled overflow gave no interrupt");
   a_sleep_async: assert property (@(posedge clk) disable iff (srst)
      (sleep && ctrl_reg.timer_on && ctrl_reg.clock_source && ctrl_reg.sync_disable
       && ext_pulse && gate_ok && ctrl_reg.prescale_select == 2'b00 && !cnt_wr)
      |=> count_reg != $past(count_reg)) else $error("async count stalled in sleep");
   a_sleep_sync_stops: assert property (@(posedge clk) disable iff (srst)
      (sleep && !ctrl_reg.sync_disable && !cnt_wr) |=> $stable(count_reg))
      else $error("synchronised count ran in sleep");
   a_read_zero_bits: assert property (@(posedge clk) disable iff (srst)
      (bus_st_reg == BUS_RD_WAIT && rd_addr_reg == OFS_APF)
      |=> hrdata_reg[7:5] == 3'b000 && hrdata_reg[3:0] == 4'h0)
      else $error("unimplemented steering bits read nonzero");
   a_ext_needs_arm: assert property (@(posedge clk) disable iff (srst)
      (ctrl_reg.clock_source && inc) |-> ext_armed)
      else $error("external count while disarmed");
   a_crystal_source: assert property (@(posedge clk) disable iff (srst)
      (ctrl_reg.crystal_enable && internal_oscillator_no_clkout)
      |-> src_level == crystal_osc_clock) else $error("crystal input not selected");
   a_gate_select: assert property (@(posedge clk) disable iff (srst)
      apf_reg[APF_GATE_SEL_BIT] |-> gate_level == master_clear_shared_pin)
      else $error("gate not taken from master-clear pin");

endmodule

// ---- tb/tb_timer1_clock_and_gate_select.sv ----
// testbench: registers, count paths, arming, gate and overflow of the timer block
module tb_timer1_clock_and_gate_select import tcg_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk = 1'b0;
   logic srst = 1'b1;
   logic hsel = 1'b1;
   logic hwrite = 1'b0;
   logic hready;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout, hresp, irq, wake, ext_pin, xtal_clk;
   logic mc_pin = 1'b0;
   logic oo_pin = 1'b0;
   logic no_clkout = 1'b1;
   logic sleep = 1'b0;
   int num_errors = 0;
   int checks = 0;
   int n, half, xtal;
   logic [31:0] rd, d;
   logic [15:0] cnt;
   logic [7:0] ofs [4] = '{OFS_IRQ_EN, OFS_APF, OFS_IRQ_CTRL, 8'h1C};
   logic [7:0] msk [4] = '{IRQ_EN_MASK, APF_MASK, IRQ_CTRL_MASK, 8'h00};

   assign hready = hreadyout;
   always #10 clk = ~clk;

   tcg_timer tcg_timer_inst (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .external_count_clock_pin(ext_pin), .crystal_osc_clock(xtal_clk),
      .master_clear_shared_pin(mc_pin), .osc_output_shared_pin(oo_pin),
      .internal_oscillator_no_clkout(no_clkout), .sleep(sleep), .irq(irq), .wake(wake));
   tcg_pulse_src tcg_pulse_src_inst (.clk(clk), .pin(ext_pin));
   tcg_pulse_src tcg_pulse_src_inst2 (.clk(clk), .pin(xtal_clk));

   // ----------------------------------------
   // bus, counter and compare helpers
   // ----------------------------------------
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= v;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask

   task automatic set_cnt(input logic [15:0] v);
      bus(1'b1, OFS_CNT_LO, {24'h0, v[7:0]});
      bus(1'b1, OFS_CNT_HI, {24'h0, v[15:8]});
   endtask

   task automatic get_cnt();
      bus(1'b0, OFS_CNT_LO, 32'h0);
      cnt[7:0] = rd[7:0];
      bus(1'b0, OFS_CNT_HI, 32'h0);
      cnt[15:8] = rd[7:0];
   endtask

   // run with control value c for n clocks from start value v
   task automatic run_int(input logic [15:0] v, input logic [7:0] c, input int n);
      set_cnt(v);
      bus(1'b1, OFS_CTRL, {24'h0, c});
      repeat (n) @(posedge clk);
      bus(1'b1, OFS_CTRL, 32'h0);
      get_cnt();
   endtask

   // run time is n plus three bus clocks, one step per 2^p instruction cycles
   function automatic logic [31:0] exp_int(input int n, input int p);
      return 32'((n + 3) >> (2 + p));
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input int tol);
      checks++;
      if ((^seen === 1'bx) || (seen > exp + tol) || (seen + tol < exp)) begin
         num_errors++;
         $display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      void'($urandom(81911));
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      for (int a = 0; a < 32; a += 4) begin
         bus(1'b0, 8'(a), 32'h0);
         check(rd, 32'h0, 0);
         check({31'h0, hresp}, 32'h0, 0);
      end
      foreach (ofs[k]) begin
         d = $urandom;
         bus(1'b1, ofs[k], d);
         bus(1'b0, ofs[k], 32'h0);
         check(rd, {24'h0, d[7:0] & msk[k]}, 0);
         bus(1'b1, ofs[k], 32'h0);
      end
      $display("test registers done");
      for (int p = 0; p < 4; p++) begin
         n = 200 + $urandom % 200;
         run_int(16'h0, {2'h0, 2'(p), 4'h1}, n);
         check({16'h0, cnt}, exp_int(n, p), 1);
      end
      $display("test internal source done");
      for (int i = 0; i < 8; i++) begin
         xtal = $urandom % 2;
         n = 3 + $urandom % 14;
         half = 2 + $urandom % 3;
         set_cnt(16'h0);
         bus(1'b1, OFS_CTRL, {26'h0, 2'(i % 4), 1'(xtal), 1'(i / 4), 2'h3});
         if (xtal == 1)
            tcg_pulse_src_inst2.burst(n, half);
         else
            tcg_pulse_src_inst.burst(n, half);
         repeat (4) @(posedge clk);
         bus(1'b1, OFS_CTRL, 32'h0);
         get_cnt();
         check({16'h0, cnt}, 32'((n - 1) >> (i % 4)), 0);
      end
      $display("test external source done");
      set_cnt(16'h0);
      bus(1'b1, OFS_CTRL, 32'h3);
      tcg_pulse_src_inst.burst(2, 2);
      tcg_pulse_src_inst.level(1'b1);
      repeat (4) @(posedge clk);
      bus(1'b1, OFS_CTRL, 32'h0);
      tcg_pulse_src_inst.level(1'b0);
      bus(1'b1, OFS_CTRL, 32'h3);
      tcg_pulse_src_inst.burst(4, 3);
      repeat (4) @(posedge clk);
      bus(1'b1, OFS_CTRL, 32'h0);
      get_cnt();
      check({16'h0, cnt}, 32'h5, 0);
      $display("test re-enable done");
      mc_pin <= 1'b1;
      oo_pin <= 1'b0;
      for (int s = 0; s < 2; s++) begin
         bus(1'b1, OFS_APF, {27'h0, 1'(s), 4'h0});
         run_int(16'h0, 8'h41, 200);
         check({16'h0, cnt}, (s == 1) ? 32'h0 : exp_int(200, 0), (s == 1) ? 0 : 1);
      end
      $display("test gate done");
      bus(1'b1, OFS_IRQ_EN, 32'h1);
      run_int(16'hFFFF, 8'h01, 40);
      check({31'h0, irq}, 32'h0, 0);
      bus(1'b0, OFS_PIR1, 32'h0);
      check(rd, 32'h1, 0);
      check({16'h0, cnt}, exp_int(40, 0) - 1, 1);
      bus(1'b1, OFS_IRQ_CTRL, 32'h40);
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h1, 0);
      bus(1'b1, OFS_PIR1, 32'h0);
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h0, 0);
      $display("test overflow done");
      sleep <= 1'b1;
      set_cnt(16'hFFFF);
      bus(1'b1, OFS_CTRL, 32'h7);
      tcg_pulse_src_inst.burst(3, 2);
      repeat (4) @(posedge clk);
      check({31'h0, wake}, 32'h1, 0);
      sleep <= 1'b0;
      bus(1'b1, OFS_CTRL, 32'h0);
      get_cnt();
      check({16'h0, cnt}, 32'h1, 0);
      $display("test sleep wake done");
      finish_test();
   end

   // watchdog: the tests need a few thousand clocks
   initial begin
      repeat (60000) @(posedge clk);
      num_errors++;
      finish_test();
   end
endmodule

// ---- tb/tcg_pulse_src.sv ----
// partner model: pulse source on a count input pin, idle low between bursts
module tcg_pulse_src (
   // clock
   input wire logic clk,
   // driven count line
   output logic pin
);
   timeunit 1ns;
   timeprecision 1ps;

   initial pin = 1'b0;

   // move the line to a new level just after an edge
   task automatic level(input logic v);
      @(posedge clk);
      pin <= v;
   endtask

   // n full pulses, each level held for half clocks
   task automatic burst(input int n, input int half);
      repeat (n) begin
         level(1'b1);
         repeat (half - 1) @(posedge clk);
         level(1'b0);
         repeat (half - 1) @(posedge clk);
      end
   endtask
endmodule
